// ### verilog/disk_track_serial_controller.sv
/*
  Serial control engine of the fixed-head disk: word address search,
  NRZI write with parity, serial read, address and track stepping, and
  the host data-break handshake. Timing tracks are decoded on the disk
  clock by the track timing module and arrive here as event records.
  Assumes host strobes are synchronous to ref_clk_i and that timing
  pulses are spaced by at least six reference clock periods.
*/
module disk_track_serial_controller (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          ce_i,
  input  wire logic                          disk_clk_i,
  input  wire logic                          load_track_unit_cmd_i,
  input  wire logic [disk_pkg::TU_BITS-1:0]  track_unit_i,
  input  wire logic                          load_address_write_cmd_i,
  input  wire logic                          load_address_read_cmd_i,
  input  wire logic [disk_pkg::ADDR_BITS-1:0] word_address_i,
  input  wire logic [disk_pkg::DATA_BITS-1:0] word_count_i,
  input  wire logic                          break_ack_i,
  input  wire logic [disk_pkg::DATA_BITS-1:0] break_data_i,
  input  wire logic                          sliced_bit_timing_i,
  input  wire logic                          sliced_address_timing_i,
  input  wire logic                          data_pulse_i,
  output logic                               break_req_o,
  output logic [disk_pkg::DATA_BITS-1:0]     break_data_o,
  output logic [disk_pkg::TU_BITS-1:0]       track_unit_select_o,
  output logic                               busy_o,
  output logic                               address_confirmed_o,
  output logic                               transfer_done_o,
  output logic                               write_enable_o,
  output logic                               write_flux_o,
  output logic                               timing_error_o
);
  import disk_pkg::*;

  // Sequencing phases of the transfer engine.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_TRANSFER
  } phase_type;

  typedef struct packed {
    logic [2:0]           evt_sync;
    logic                 aligned;
    phase_type            phase;
    logic                 write_mode;
    logic [ADDR_BITS-1:0] word_address;
    logic [TU_BITS-1:0]   track_unit_select;
    logic [DATA_BITS-1:0] transfer_word_counter;
    logic [DATA_BITS-1:0] disk_data_buffer;
    logic                 mismatch;
    logic                 inc_active;
    logic                 carry;
    logic                 break_req;
    logic [DATA_BITS-1:0] break_data;
    logic                 busy;
    logic                 found;
    logic                 done;
    logic                 write_enable;
    logic                 write_flux_flipflop;
    logic                 timing_error;
  } ctl_state_type;

  ctl_state_type        state_reg;
  ctl_state_type        state_next;
  timing_if             tif ();
  logic                 evt_seen;
  logic                 bit_evt;
  logic                 start_evt;
  logic                 addr_window;
  logic                 data_window;
  logic                 shift_window;
  logic                 addr_lsb;
  logic                 addr_out;
  logic [DATA_BITS-1:0] count_inc;
  logic                 count_overflow;
  logic                 match_ok;

  // Timing pins and the control levels go to the disk clock side.
  assign tif.bit_timing     = sliced_bit_timing_i;
  assign tif.address_timing = sliced_address_timing_i;
  assign tif.data_pulse     = data_pulse_i;
  assign tif.ce             = ce_i;
  assign tif.reset_n        = reset_n_i;

  track_timing u_timing (
    .disk_clk_i (disk_clk_i),
    .tif        (tif.timing)
  );

  // A change between the second and third toggle stages marks one new
  // record. The record itself is held by the disk side until the next
  // event, so it is stable whenever the change is seen here.
  assign evt_seen  = state_reg.evt_sync[2] ^ state_reg.evt_sync[1];
  assign bit_evt   = evt_seen && (tif.evt_kind == EVT_BIT);
  assign start_evt = evt_seen && (tif.evt_kind == EVT_START);

  assign shift_window = (tif.evt_index >= FIRST_SHIFT) &&
                        (tif.evt_index <= LAST_SHIFT);
  assign addr_window  = shift_window && (tif.evt_index <= LAST_ADDR_SHIFT);
  assign data_window  = (tif.evt_index >= FIRST_DATA_PULSE) &&
                        (tif.evt_index <= LAST_DATA_PULSE);

  assign addr_lsb = state_reg.word_address[0];
  assign addr_out = state_reg.inc_active ? (addr_lsb ^ state_reg.carry)
                                         : addr_lsb;

  assign count_inc      = state_reg.transfer_word_counter + COUNT_STEP;
  assign count_overflow = (count_inc == COUNT_DONE);

  // A word buffer still waiting on the host blocks a match, so late
  // service costs one revolution instead of corrupting a word.
  assign match_ok = !state_reg.mismatch && !state_reg.break_req;

  // Whole next-state of the engine; ce_i low freezes every field unless reset_n_i is low.
  always_comb begin
    state_next = state_reg;
    if (!reset_n_i) begin
      state_next       = '0;
      state_next.phase = ST_IDLE;
    end else if (ce_i) begin
      state_next.done     = 1'b0;
      state_next.evt_sync = {state_reg.evt_sync[1:0], tif.evt_toggle};

      // Host answers a break; a write break refills the buffer.
      if (state_reg.break_req && break_ack_i) begin
        state_next.break_req = 1'b0;
        if (state_reg.write_mode) begin
          state_next.disk_data_buffer = break_data_i;
        end
      end

      if (state_reg.phase == ST_IDLE) begin
        if (load_track_unit_cmd_i) begin
          state_next.track_unit_select = track_unit_i;
        end
        if (load_address_write_cmd_i || load_address_read_cmd_i) begin
          state_next.word_address          = word_address_i;
          state_next.transfer_word_counter = word_count_i;
          state_next.write_mode            = load_address_write_cmd_i;
          state_next.phase                 = ST_SEARCH;
          state_next.busy                  = 1'b1;
          state_next.mismatch              = 1'b1;
          state_next.inc_active            = 1'b0;
          state_next.carry                 = 1'b0;
          state_next.aligned               = 1'b0;
          state_next.timing_error          = 1'b0;
          state_next.write_flux_flipflop   = 1'b0;
          state_next.break_req = load_address_write_cmd_i;
        end
      end

      if (start_evt) begin
        state_next.aligned = 1'b1;
        if (state_reg.busy && state_reg.aligned &&
            tif.evt_index != PULSES_PER_WORD) begin
          state_next.timing_error = 1'b1;
        end
      end

      case (state_reg.phase)
        ST_IDLE: begin
          state_next.write_enable = 1'b0;
        end

        ST_SEARCH: begin
          if (bit_evt && addr_window) begin
            state_next.word_address =
              {addr_out, state_reg.word_address[ADDR_BITS-1:1]};
            if (addr_out != tif.evt_addr_bit) begin
              state_next.mismatch = 1'b1;
            end
            if (state_reg.inc_active) begin
              state_next.carry = addr_lsb & state_reg.carry;
            end
          end
          if (start_evt) begin
            state_next.mismatch   = 1'b0;
            state_next.inc_active = 1'b0;
            if (state_reg.inc_active && state_reg.carry) begin
              state_next.track_unit_select =
                state_reg.track_unit_select + TU_STEP;
            end
            if (match_ok && state_reg.aligned) begin
              state_next.phase        = ST_TRANSFER;
              state_next.found        = 1'b1;
              state_next.write_enable = state_reg.write_mode;
            end
          end
        end

        ST_TRANSFER: begin
          if (bit_evt && data_window) begin
            if (state_reg.write_mode) begin
              if (state_reg.disk_data_buffer[DATA_BITS-1]) begin
                state_next.write_flux_flipflop =
                  ~state_reg.write_flux_flipflop;
              end
              state_next.disk_data_buffer =
                {state_reg.disk_data_buffer[DATA_BITS-2:0], 1'b0};
            end else begin
              state_next.disk_data_buffer =
                {state_reg.disk_data_buffer[DATA_BITS-2:0],
                 tif.evt_data_bit};
            end
          end
          if (bit_evt && tif.evt_index == PARITY_PULSE &&
              state_reg.write_mode) begin
            state_next.write_flux_flipflop = 1'b0;
          end
          if (start_evt) begin
            state_next.found                 = 1'b0;
            state_next.write_enable          = 1'b0;
            state_next.transfer_word_counter = count_inc;
            state_next.mismatch              = 1'b0;
            if (!state_reg.write_mode) begin
              state_next.break_data = state_reg.disk_data_buffer;
              state_next.break_req  = 1'b1;
            end
            if (count_overflow) begin
              state_next.phase = ST_IDLE;
              state_next.busy  = 1'b0;
              state_next.done  = 1'b1;
            end else begin
              state_next.phase      = ST_SEARCH;
              state_next.inc_active = 1'b1;
              state_next.carry      = 1'b1;
              if (state_reg.write_mode) begin
                state_next.break_req = 1'b1;
              end
            end
          end
        end

        default: begin
          state_next.phase = ST_IDLE;
          state_next.busy  = 1'b0;
        end
      endcase
    end
  end

  // Single register bank of the reference clock domain.
  always_ff @(posedge ref_clk_i) begin
    state_reg <= state_next;
  end

  // Every output is a field of the registered state.
  assign break_req_o         = state_reg.break_req;
  assign break_data_o        = state_reg.break_data;
  assign track_unit_select_o = state_reg.track_unit_select;
  assign busy_o              = state_reg.busy;
  assign address_confirmed_o = state_reg.found;
  assign transfer_done_o     = state_reg.done;
  assign write_enable_o      = state_reg.write_enable;
  assign write_flux_o        = state_reg.write_flux_flipflop;
  assign timing_error_o      = state_reg.timing_error;
endmodule

// ### verilog/disk_pkg.sv
/*
  Shared constants and types of the disk track serial controller.
  Assumes a single compile of this package before every design file.
*/
package disk_pkg;
  localparam int         DATA_BITS        = 12;
  localparam int         ADDR_BITS        = 11;
  localparam int         TU_BITS          = 6;
  localparam int         IDX_BITS         = 4;
  localparam logic [3:0] PULSES_PER_WORD  = 4'hd;
  localparam logic [3:0] FIRST_DATA_PULSE = 4'h1;
  localparam logic [3:0] LAST_DATA_PULSE  = 4'hc;
  localparam logic [3:0] FIRST_SHIFT      = 4'h2;
  localparam logic [3:0] LAST_ADDR_SHIFT  = 4'hc;
  localparam logic [3:0] LAST_SHIFT       = 4'hd;
  localparam logic [3:0] PARITY_PULSE     = 4'hd;
  localparam logic [3:0] IDX_MAX          = 4'hf;
  localparam logic [5:0] TU_STEP          = 6'h01;
  localparam logic [11:0] COUNT_STEP      = 12'h001;
  localparam logic [11:0] COUNT_DONE      = 12'h000;

  // Kind of timing event passed from the disk clock to the engine.
  typedef enum logic [1:0] {EVT_NONE, EVT_BIT, EVT_START} event_kind_type;
endpackage

// ### verilog/timing_if.sv
/*
  Carrier between the engine and the timing-track logic.
  Assumes the engine drives pins, enable and reset; the timing side
  answers with one toggle-marked event record that it holds stable.
*/
interface timing_if;
  import disk_pkg::*;
  logic                    bit_timing;
  logic                    address_timing;
  logic                    data_pulse;
  logic                    ce;
  logic                    reset_n;
  logic                    evt_toggle;
  event_kind_type          evt_kind;
  logic [IDX_BITS-1:0]     evt_index;
  logic                    evt_addr_bit;
  logic                    evt_data_bit;

  modport timing (input  bit_timing, address_timing, data_pulse, ce,
                  reset_n,
                  output evt_toggle, evt_kind, evt_index, evt_addr_bit,
                  evt_data_bit);
  modport engine (output bit_timing, address_timing, data_pulse, ce,
                  reset_n,
                  input  evt_toggle, evt_kind, evt_index, evt_addr_bit,
                  evt_data_bit);
endinterface

// ### verilog/track_timing.sv
/*
  Timing-track logic on the disk clock: address bit detector, bit pulse
  count and word-period start, reported as toggle-marked event records.
  Assumes timing and data pulses last at least one disk clock period.
*/
module track_timing (
  input wire logic disk_clk_i,
  timing_if.timing tif
);
  import disk_pkg::*;

  typedef struct packed {
    logic [1:0]          rst_sync;
    logic [1:0]          ce_sync;
    logic [1:0]          bit_sync;
    logic [1:0]          addr_sync;
    logic [1:0]          data_sync;
    logic                bit_prev;
    logic                addr_prev;
    logic                address_bit_detector;
    logic                data_prev;
    logic                data_seen;
    logic [3:0]          count;
    logic                toggle;
    event_kind_type      kind;
    logic [3:0]          index;
    logic                addr_bit;
    logic                data_bit;
  } tim_state_type;

  tim_state_type state_reg;
  tim_state_type state_next;
  logic          bit_rise;
  logic          addr_rise;
  logic          data_rise;

  // Edges are taken from the second synchroniser stage only.
  assign bit_rise  = state_reg.bit_sync[1] & ~state_reg.bit_prev;
  assign addr_rise = state_reg.addr_sync[1] & ~state_reg.addr_prev;
  assign data_rise = state_reg.data_sync[1] & ~state_reg.data_prev;

  // The two tracks are 90 degrees apart, so a bit pulse and an address
  // pulse never share an edge; the bit pulse is favoured if they do.
  always_comb begin
    state_next = state_reg;
    state_next.rst_sync  = {state_reg.rst_sync[0], tif.reset_n};
    state_next.ce_sync   = {state_reg.ce_sync[0], tif.ce};
    state_next.bit_sync  = {state_reg.bit_sync[0], tif.bit_timing};
    state_next.addr_sync = {state_reg.addr_sync[0], tif.address_timing};
    state_next.data_sync = {state_reg.data_sync[0], tif.data_pulse};
    if (!state_reg.rst_sync[1]) begin
      state_next.bit_prev             = 1'b0;
      state_next.addr_prev            = 1'b0;
      state_next.data_prev            = 1'b0;
      state_next.address_bit_detector = 1'b0;
      state_next.data_seen            = 1'b0;
      state_next.count                = 4'h0;
      state_next.toggle               = 1'b0;
      state_next.kind                 = EVT_NONE;
      state_next.index                = 4'h0;
    end else if (state_reg.ce_sync[1]) begin
      state_next.bit_prev  = state_reg.bit_sync[1];
      state_next.addr_prev = state_reg.addr_sync[1];
      state_next.data_prev = state_reg.data_sync[1];
      if (data_rise) begin
        state_next.data_seen = 1'b1;
      end
      if (bit_rise) begin
        state_next.address_bit_detector = 1'b0;
        if (state_reg.count != IDX_MAX) begin
          state_next.count = state_reg.count + 4'h1;
        end
        state_next.toggle    = ~state_reg.toggle;
        state_next.kind      = EVT_BIT;
        state_next.index     = state_reg.count + 4'h1;
        state_next.addr_bit  = state_reg.address_bit_detector;
        state_next.data_bit  = state_reg.data_seen | data_rise;
        state_next.data_seen = 1'b0;
      end else if (addr_rise) begin
        if (state_reg.address_bit_detector) begin
          state_next.toggle = ~state_reg.toggle;
          state_next.kind   = EVT_START;
          state_next.index  = state_reg.count;
          state_next.count  = 4'h0;
          state_next.address_bit_detector = 1'b0;
        end else begin
          state_next.address_bit_detector = 1'b1;
        end
      end
    end
  end

  // Single register bank of the disk clock domain.
  always_ff @(posedge disk_clk_i) begin
    state_reg <= state_next;
  end

  assign tif.evt_toggle   = state_reg.toggle;
  assign tif.evt_kind     = state_reg.kind;
  assign tif.evt_index    = state_reg.index;
  assign tif.evt_addr_bit = state_reg.addr_bit;
  assign tif.evt_data_bit = state_reg.data_bit;
endmodule

// ### sim/disk_track_serial_controller_assertions.sv
/*
  Checker for the disk track serial controller, bound to its top ports.
  Assumes one reference clock domain with synchronous active-low reset.
*/
module disk_track_serial_controller_assertions (
  input wire logic                         ref_clk_i,
  input wire logic                         reset_n_i,
  input wire logic                         ce_i,
  input wire logic                         load_address_write_cmd_i,
  input wire logic                         load_address_read_cmd_i,
  input wire logic                         break_ack_i,
  input wire logic                         break_req_o,
  input wire logic [disk_pkg::TU_BITS-1:0] track_unit_select_o,
  input wire logic                         busy_o,
  input wire logic                         address_confirmed_o,
  input wire logic                         transfer_done_o,
  input wire logic                         write_enable_o,
  input wire logic                         write_flux_o
);
  import disk_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // An idle controller takes a command; write also fetches a word.
  sequence s_write_cmd;
    !busy_o && ce_i && load_address_write_cmd_i;
  endsequence
  sequence s_read_cmd;
    !busy_o && ce_i && load_address_read_cmd_i && !load_address_write_cmd_i;
  endsequence
  sequence s_fetching;
    busy_o && break_req_o;
  endsequence

  a_write_start_req: assert property (s_write_cmd |=> s_fetching)
    else $error("write command did not start with a break request");
  a_read_start: assert property (
    s_read_cmd |=> busy_o && !break_req_o && !write_enable_o)
    else $error("read command did not start a read");
  a_break_release: assert property (
    break_req_o && break_ack_i && ce_i |=> !break_req_o)
    else $error("break request held after acknowledge");
  a_done_idle: assert property (
    transfer_done_o && ce_i && !load_address_write_cmd_i &&
    !load_address_read_cmd_i |=> !transfer_done_o && !busy_o)
    else $error("transfer end did not leave the controller idle");
  a_confirm_busy: assert property (address_confirmed_o |-> busy_o)
    else $error("address confirmed while idle");
  a_write_gate: assert property (
    $rose(write_enable_o) |-> address_confirmed_o)
    else $error("writer enabled before the address was found");
  // The flux may only move while the writer is on.
  a_flux_hold: assert property (
    $changed(write_flux_o) |-> write_enable_o)
    else $error("write flux moved outside a write period");
  a_parity_clear: assert property (
    $fell(write_enable_o) |-> !write_flux_o)
    else $error("write flux not cleared by the parity bit");
  a_track_step: assert property (
    $past(busy_o) && busy_o && $changed(track_unit_select_o) |->
    track_unit_select_o == $past(track_unit_select_o) + TU_STEP)
    else $error("track and unit changed by other than one step");
  a_reset_clear: assert property (disable iff (1'b0)
    !reset_n_i |=> !busy_o && !write_flux_o && !break_req_o &&
    !address_confirmed_o)
    else $error("reset did not clear the sequencing state");
endmodule

// ### sim/disk_heads.sv
/*
  Disk head model: timing track pulses, stored words and a write decoder.
  Assumes the controller synchronises the pins on its own disk clock.
*/
module disk_heads #(parameter int START_IDX = 2044) (
  input  wire logic   write_flux_i,
  input  wire logic   write_enable_i,
  output logic        bit_timing_o,
  output logic        address_timing_o,
  output logic        data_pulse_o,
  output logic [10:0] position_o,
  output logic [10:0] written_at_o,
  output logic [12:0] written_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] flux;
  logic [12:0] word;
  logic        wr;
  int          idx;

  // Positions four apart differ by one; neighbours by 1000 octal.
  function automatic logic [10:0] addr_of(input int i);
    return 11'((i % 4) * 512 + i / 4);
  endfunction
  task automatic addr_pulse();
    address_timing_o = 1'b1;
    #150;
    address_timing_o = 1'b0;
    #550;
  endtask
  // Data pulse overlaps the bit pulse; an address pulse follows when a is set.
  task automatic bit_slot(input logic d, input logic a);
    data_pulse_o = d;
    #50;
    bit_timing_o = 1'b1;
    #400;
    bit_timing_o = 1'b0;
    data_pulse_o = 1'b0;
    #250;
    if (a) begin
      addr_pulse();
    end else begin
      #700;
    end
  endtask

  // Two gap pulses, one control pulse, 13 bit pulses.
  initial begin
    bit_timing_o = 1'b0;
    address_timing_o = 1'b0;
    data_pulse_o = 1'b0;
    written_o = '0;
    written_at_o = '0;
    flux = '0;
    wr = 1'b0;
    idx = START_IDX;
    position_o = addr_of(idx);
    #2000;
    forever begin
      // Flux changes between slot samples decode as ones.
      flux[13] = write_flux_i;
      if (wr) begin
        written_at_o = position_o;
        for (int k = 1; k < 14; k++) written_o[13-k] = flux[k] ^ flux[k-1];
      end
      wr = 1'b0;
      position_o = addr_of(idx);
      word = {1'b1, position_o, 1'b0};
      word[0] = ^word[12:1];
      addr_pulse();
      addr_pulse();
      addr_pulse();
      for (int k = 1; k < 14; k++) begin
        flux[k-1] = write_flux_i;
        if (k == 7) wr = write_enable_i;
        bit_slot(word[13-k], k < 12 && position_o[k-1]);
      end
      idx = (idx + 1) % 2048;
    end
  end
endmodule

// ### sim/tb.sv
/*
  Testbench of the disk track serial controller with the disk head model.
  Assumes the host answers each break request one falling edge later.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import disk_pkg::*;
  logic        ref_clk = 0, disk_clk = 0, reset_n = 0, ce = 1;
  logic        ltu = 0, lw = 0, lr = 0, ack = 0;
  logic        bt, at, dp, req, busy, conf, done, we, flux, terr;
  logic [5:0]  tu = 0, tus;
  logic [10:0] wa = 0, pos, wat;
  logic [11:0] wcnt = 0, bdo, rdata;
  logic [11:0] bdi = 12'hb36;
  logic [12:0] wword;
  int          failures = 0, total_checks = 0, nreq = 0;

  disk_track_serial_controller u_dut (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .ce_i(ce),
    .disk_clk_i(disk_clk), .load_track_unit_cmd_i(ltu),
    .track_unit_i(tu), .load_address_write_cmd_i(lw),
    .load_address_read_cmd_i(lr), .word_address_i(wa),
    .word_count_i(wcnt), .break_ack_i(ack), .break_data_i(bdi),
    .sliced_bit_timing_i(bt), .sliced_address_timing_i(at),
    .data_pulse_i(dp), .break_req_o(req), .break_data_o(bdo),
    .track_unit_select_o(tus), .busy_o(busy),
    .address_confirmed_o(conf), .transfer_done_o(done),
    .write_enable_o(we), .write_flux_o(flux), .timing_error_o(terr));
  disk_heads u_disk (.write_flux_i(flux), .write_enable_i(we),
    .bit_timing_o(bt), .address_timing_o(at), .data_pulse_o(dp),
    .position_o(pos), .written_at_o(wat), .written_o(wword));

  // Two unrelated clocks; the disk clock is skewed off the reference.
  initial forever #50 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #24 disk_clk = ~disk_clk;
  end
  // Host side of the data break; read words are taken on the ack edge.
  always @(negedge ref_clk) begin
    ack <= req && !ack;
    if (req && !ack) nreq <= nreq + 1;
  end
  always @(posedge ref_clk) if (req && ack) rdata <= bdo;

  function automatic logic [10:0] nxt(input logic [10:0] a);
    int i;
    i = ((a % 512) * 4 + a / 512 + 1) % 2048;
    return 11'((i % 4) * 512 + i / 4);
  endfunction
  task automatic check(input string nm, input logic [12:0] e,
                       input logic [12:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic start(input logic w, input logic [5:0] t,
                       input logic [10:0] a, input logic [11:0] c);
    @(negedge ref_clk);
    {ltu, tu, lw, lr, wa, wcnt} = {1'b1, t, w, !w, a, c};
    @(negedge ref_clk);
    {ltu, lw, lr} = 3'h0;
    check("busy", 13'h1, 13'(busy));
    check("first request", 13'(w), 13'(req));
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    check("transfer done", 13'h1, 13'(done));
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic t_idle();
    check("idle outputs", 13'h0, 13'({busy, flux, req, we, conf}));
    // A command given while the clock enable is low must be lost.
    ce = 1'b0;
    lr = 1'b1;
    @(negedge ref_clk);
    lr = 1'b0;
    ce = 1'b1;
    @(negedge ref_clk);
    check("frozen command", 13'h0, 13'(busy));
  endtask
  // Write at 3777 lands on 0000 and steps the track into the next unit.
  task automatic t_wrap();
    int n;
    start(1'b1, 6'h0f, 11'h7ff, 12'hffe);
    n = 0;
    while (tus === 6'h0f && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    check("track step", 13'h10, 13'(tus));
    check("break count", 13'h2, 13'(nreq));
    check("write position", 13'h0, 13'(wat));
    check("written word", {12'hb36, 1'b1}, wword);
    reset_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    t_idle();
  endtask
  // Read one word a few positions ahead of the heads.
  task automatic t_read();
    logic [10:0] a;
    a = nxt(nxt(nxt(pos)));
    start(1'b0, 6'h03, a, 12'hfff);
    wait_done();
    check("read word", 13'({1'b1, nxt(a)}), 13'(rdata));
    check("track kept", 13'h3, 13'(tus));
    check("timing error", 13'h0, 13'(terr));
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The whole run needs well under a millisecond of disk time.
  initial begin
    #1000000;
    failures++;
    summarize();
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    t_idle();
    t_wrap();
    t_read();
    summarize();
  end
endmodule

bind disk_track_serial_controller disk_track_serial_controller_assertions
  u_chk (.ref_clk_i, .reset_n_i, .ce_i, .load_address_write_cmd_i,
  .load_address_read_cmd_i, .break_ack_i, .break_req_o, .busy_o,
  .track_unit_select_o, .address_confirmed_o, .transfer_done_o,
  .write_enable_o, .write_flux_o);
